// ==== hw/cgpd_cfg.svh ====
// constants for the clock generator power-down control
`ifndef CGPD_CFG_SVH
`define CGPD_CFG_SVH

// width of the stand-by divider code
`define CGPD_DIV_CODE_W 4
// reset value of the stand-by divider code
`define CGPD_DIV_CODE_RESET 4'h8
// divisor = base - 2 * code, so the half period is half_base - code
`define CGPD_DIV_HALF_BASE 5'h11
// code substituted when software leaves the code at zero
`define CGPD_DIV_CODE_SAFE 4'h1
// width of the half-period counter
`define CGPD_DIV_CNT_W 5
// reset value of the mode-select (power-down) bit
`define CGPD_MODE_BIT_RESET 1'b0
// reset level of the synchronised sleep pin (awake)
`define CGPD_SLEEP_IDLE 1'b1
// level of the memory clock when the divider starts
`define CGPD_DIV_START_LEVEL 1'b1

`endif

// ==== hw/cgpd_div_if.sv ====
// carrier between the state logic and the stand-by divider
`timescale 1ns/1ps
interface cgpd_div_if;
    logic run;
    cgpd_pkg::cgpd_code_type code;
    logic div_clk;

    // state logic side
    modport ctrl (output run, output code, input div_clk);
    // divider side
    modport div (input run, input code, output div_clk);
endinterface

// ==== hw/cgpd_pkg.sv ====
// types shared by the power-down control modules
package cgpd_pkg;

    // operating state of the clock generator
    typedef enum logic [1:0] {
        CGPD_RUN,
        CGPD_STANDBY1,
        CGPD_STANDBY2
    } cgpd_state_type;

    // stand-by divider code
    typedef logic [3:0] cgpd_code_type;

endpackage

// ==== hw/cgpd_power_ctrl.sv ====
// power-down control of a dual-pll clock generator
// How it works
// - sleep low, mode bit zero: stand-by one
// - stand-by one: plls stopped, video high
// - stand-by one: memory clock is reference divided
// - divisor equals 34 minus twice the code, code zero acting as one
// - stand-by two: all clocks, oscillator stopped
// - registers keep contents through stand-by two
// - stand-by weakens pull-up; floating pin wakes
// - sleep pin high returns to normal
// - programming refused during any stand-by
`timescale 1ns/1ps
`include "cgpd_cfg.svh"
module cgpd_power_ctrl (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic sleep_request_n_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_powerdown_bit_in,
    input wire logic div_wr_in,
    input wire logic [3:0] div_code_in,
    input wire logic pll_video_clk_in,
    input wire logic pll_mem_clk_in,
    output logic video_clock_out,
    output logic mem_clock_out,
    output logic pll_run_out,
    output logic ref_osc_run_out,
    output logic sleep_pullup_weak_out,
    output logic [1:0] standby_state_out,
    output logic mode_config_out,
    output logic [3:0] standby_divider_code_out,
    output logic prog_refused_out
);
    // two-stage synchroniser for the sleep pin
    logic sleep_meta_r;
    logic sleep_sync_r;

    // state machine
    cgpd_pkg::cgpd_state_type state_r;
    cgpd_pkg::cgpd_state_type state_nxt;

    // programmed registers
    logic mode_config_register_r;
    logic mode_config_register_nxt;
    cgpd_pkg::cgpd_code_type standby_divider_code_r;
    cgpd_pkg::cgpd_code_type standby_divider_code_nxt;

    // registered outputs
    logic video_clock_r;
    logic video_clock_nxt;
    logic mem_clock_r;
    logic mem_clock_nxt;
    logic pll_run_r;
    logic ref_osc_run_r;
    logic pullup_weak_r;
    logic refused_r;
    logic refused_nxt;

    // decoded state
    logic in_run;
    logic in_standby1;
    logic in_standby2;
    logic write_req;
    logic write_ok;
    cgpd_pkg::cgpd_code_type divider_code_eff;
    logic sleep_asked;
    logic next_awake;
    logic next_osc_on;

    // true only in the state in which the plls and all clocks run
    function automatic logic is_awake(input cgpd_pkg::cgpd_state_type s);
        return (s == cgpd_pkg::CGPD_RUN);
    endfunction

    // true in every state that still needs the reference oscillator
    function automatic logic osc_needed(input cgpd_pkg::cgpd_state_type s);
        return (s != cgpd_pkg::CGPD_STANDBY2);
    endfunction

    cgpd_div_if div_bus ();

    // the pin is asynchronous to the reference clock
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sleep_meta_r <= `CGPD_SLEEP_IDLE;
            sleep_sync_r <= `CGPD_SLEEP_IDLE;
        end else begin
            sleep_meta_r <= sleep_request_n_in;
            sleep_sync_r <= sleep_meta_r;
        end
    end

    // state decode
    assign in_run = is_awake(state_r);
    assign in_standby1 = (state_r == cgpd_pkg::CGPD_STANDBY1);
    assign in_standby2 = !osc_needed(state_r);

    // a low pin asks for stand-by; a pin driven or floated high asks for run
    assign sleep_asked = !sleep_sync_r;

    // choose the stand-by mode when the pin falls, leave when it rises
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cgpd_pkg::CGPD_RUN: begin
                if (sleep_asked) begin
                    if (mode_config_register_r) begin
                        state_nxt = cgpd_pkg::CGPD_STANDBY2;
                    end else begin
                        state_nxt = cgpd_pkg::CGPD_STANDBY1;
                    end
                end
            end
            cgpd_pkg::CGPD_STANDBY1: begin
                if (sleep_sync_r) begin
                    state_nxt = cgpd_pkg::CGPD_RUN;
                end
            end
            cgpd_pkg::CGPD_STANDBY2: begin
                if (sleep_sync_r) begin
                    state_nxt = cgpd_pkg::CGPD_RUN;
                end
            end
            default: begin
                state_nxt = cgpd_pkg::CGPD_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_r <= cgpd_pkg::CGPD_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // power controls follow the next state, so they switch together with the state register
    assign next_awake = is_awake(state_nxt);
    assign next_osc_on = osc_needed(state_nxt);

    // writes only land while running; also blocked in the cycle stand-by is entered
    assign write_req = cfg_wr_in | div_wr_in;
    assign write_ok = in_run && next_awake;
    assign refused_nxt = write_req && !write_ok;

    // register contents are only ever changed by an accepted write
    assign mode_config_register_nxt = (cfg_wr_in && write_ok) ? cfg_powerdown_bit_in : mode_config_register_r;
    assign standby_divider_code_nxt = (div_wr_in && write_ok) ? div_code_in : standby_divider_code_r;

    // programmed registers
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            mode_config_register_r <= `CGPD_MODE_BIT_RESET;
            standby_divider_code_r <= `CGPD_DIV_CODE_RESET;
        end else begin
            mode_config_register_r <= mode_config_register_nxt;
            standby_divider_code_r <= standby_divider_code_nxt;
        end
    end

    // code zero has no divisor; fall back to the slowest one
    assign divider_code_eff = (standby_divider_code_r == 4'h0) ? `CGPD_DIV_CODE_SAFE : standby_divider_code_r;

    // divider runs only in stand-by one
    assign div_bus.run = in_standby1;
    assign div_bus.code = divider_code_eff;

    cgpd_standby_divider u_divider (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .div_port(div_bus)
    );

    // output clock selection per state
    assign video_clock_nxt = in_run ? pll_video_clk_in : in_standby1;
    assign mem_clock_nxt = in_run ? pll_mem_clk_in : (in_standby1 && div_bus.div_clk);

    // clock output flops keep the pins free of decode glitches
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            video_clock_r <= 1'b0;
            mem_clock_r <= 1'b0;
        end else begin
            video_clock_r <= video_clock_nxt;
            mem_clock_r <= mem_clock_nxt;
        end
    end

    // power controls for the plls, the oscillator and the pin's pull-up
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pll_run_r <= 1'b1;
            ref_osc_run_r <= 1'b1;
            pullup_weak_r <= 1'b0;
        end else begin
            pll_run_r <= next_awake;
            ref_osc_run_r <= next_osc_on;
            pullup_weak_r <= !next_awake;
        end
    end

    // one-cycle pulse for a refused write
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            refused_r <= 1'b0;
        end else begin
            refused_r <= refused_nxt;
        end
    end

    // outputs
    assign video_clock_out = video_clock_r;
    assign mem_clock_out = mem_clock_r;
    assign pll_run_out = pll_run_r;
    assign ref_osc_run_out = ref_osc_run_r;
    assign sleep_pullup_weak_out = pullup_weak_r;
    assign standby_state_out = {in_standby2, in_standby1};
    assign mode_config_out = mode_config_register_r;
    assign standby_divider_code_out = standby_divider_code_r;
    assign prog_refused_out = refused_r;
endmodule

// ==== hw/cgpd_standby_divider.sv ====
// divides the reference clock by the stand-by divisor
`timescale 1ns/1ps
`include "cgpd_cfg.svh"
module cgpd_standby_divider (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    cgpd_div_if.div div_port
);
    logic [`CGPD_DIV_CNT_W-1:0] cnt_r;
    logic [`CGPD_DIV_CNT_W-1:0] cnt_nxt;
    logic level_r;
    logic level_nxt;
    logic [`CGPD_DIV_CNT_W-1:0] half_period;
    logic half_done;

    // half period in reference cycles: 17 - code gives divisor 34 - 2 * code
    assign half_period = `CGPD_DIV_HALF_BASE - {1'b0, div_port.code};
    assign half_done = (cnt_r == half_period - 5'h01);

    // counter restarts whenever the divider is idle, so each stand-by starts clean
    assign cnt_nxt = !div_port.run ? '0 : (half_done ? '0 : cnt_r + 5'h01);
    assign level_nxt = !div_port.run ? `CGPD_DIV_START_LEVEL : (half_done ? ~level_r : level_r);

    // counter and output level
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cnt_r <= '0;
            level_r <= `CGPD_DIV_START_LEVEL;
        end else begin
            cnt_r <= cnt_nxt;
            level_r <= level_nxt;
        end
    end

    assign div_port.div_clk = level_r;
endmodule

// ==== tb/cgpd_pm_model.sv ====
// power-management logic that drives the sleep pin
`timescale 1ns/1ps
module cgpd_pm_model (
    input wire logic ref_clk_in,
    input wire logic sleep_in,
    output logic sleep_request_n_out
);
    initial sleep_request_n_out = 1'b1;
    // pulls low on request, else drives the pin high, as the pull-up would
    always @(posedge ref_clk_in) sleep_request_n_out <= #1 !sleep_in;
endmodule

// ==== tb/cgpd_power_ctrl_asserts.sv ====
// port assertions for the power-down control
`timescale 1ns/1ps
module cgpd_pc_asserts (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic sleep_request_n_in,
    input wire logic cfg_wr_in,
    input wire logic div_wr_in,
    input wire logic pll_video_clk_in,
    input wire logic pll_mem_clk_in,
    input wire logic video_clock_out,
    input wire logic mem_clock_out,
    input wire logic pll_run_out,
    input wire logic ref_osc_run_out,
    input wire logic sleep_pullup_weak_out,
    input wire logic [1:0] standby_state_out,
    input wire logic mode_config_out,
    input wire logic [3:0] standby_divider_code_out,
    input wire logic prog_refused_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic mem_q;
    logic [1:0] seen_r;
    logic [4:0] hcnt_r;
    // expected half period: 17 minus the code, code zero acting as one
    wire logic [4:0] half = 5'h11 - ((standby_divider_code_out == 4'h0) ? 5'h1 : {1'b0, standby_divider_code_out});
    // counts cycles between memory clock edges while in stand-by one
    always_ff @(posedge ref_clk_in) begin
        mem_q <= mem_clock_out;
        if (!reset_n_in || standby_state_out != 2'h1) begin
            hcnt_r <= 5'h1;
            seen_r <= 2'h0;
        end else if (mem_clock_out != mem_q) begin
            hcnt_r <= 5'h1;
            seen_r <= (seen_r == 2'h2) ? 2'h2 : seen_r + 2'h1;
        end else begin
            hcnt_r <= hcnt_r + 5'h1;
        end
    end
    sequence s_pin_low;
        !sleep_request_n_in [*3];
    endsequence
    sequence s_pin_high;
        sleep_request_n_in [*3];
    endsequence
    chk_enter_mode: assert property (s_pin_low |=> standby_state_out == {mode_config_out, !mode_config_out})
        else $error("stand-by entry wrong");
    chk_wake_run: assert property (s_pin_high |=> standby_state_out == 2'h0)
        else $error("no wake");
    property p_video_high;
        standby_state_out == 2'h1 && $past(standby_state_out) == 2'h1 |-> video_clock_out;
    endproperty
    property p_stby2_quiet;
        $past(standby_state_out) == 2'h2 && standby_state_out == 2'h2 |-> !video_clock_out && !mem_clock_out;
    endproperty
    property p_write_refused;
        (cfg_wr_in || div_wr_in) && standby_state_out != 2'h0 |=>
            prog_refused_out && $stable(standby_divider_code_out) && $stable(mode_config_out);
    endproperty
    property p_run_pass;
        $past(reset_n_in) && $past(standby_state_out) == 2'h0 |->
            video_clock_out == $past(pll_video_clk_in) && mem_clock_out == $past(pll_mem_clk_in);
    endproperty
    chk_video_high: assert property (p_video_high)
        else $error("video not high");
    chk_run_pass: assert property (p_run_pass)
        else $error("clock not passed in run");
    chk_pll_stop: assert property (standby_state_out != 2'h0 |-> !pll_run_out && sleep_pullup_weak_out)
        else $error("pll or pull-up wrong");
    chk_osc_stop: assert property (ref_osc_run_out == (standby_state_out != 2'h2))
        else $error("oscillator state wrong");
    chk_stby2_quiet: assert property (p_stby2_quiet)
        else $error("clock runs in stand-by two");
    chk_write_refused: assert property (p_write_refused)
        else $error("write not refused");
    chk_mem_half: assert property (seen_r == 2'h2 && mem_clock_out != mem_q |-> hcnt_r == half)
        else $error("memory clock half period wrong");
endmodule
bind cgpd_power_ctrl cgpd_pc_asserts u_chk (.*);

// ==== tb/test_cgpd_power_ctrl.sv ====
// self-checking bench for the power-down control
`timescale 1ns/1ps
module test_cgpd_power_ctrl;
    logic ref_clk_in = 0, reset_n_in = 0, sleep_req = 0, cfg_wr_in = 0, cfg_powerdown_bit_in = 0, div_wr_in = 0;
    logic pll_video_clk_in = 0, pll_mem_clk_in = 0, sleep_request_n_in;
    logic [3:0] div_code_in = 4'h0, standby_divider_code_out;
    logic video_clock_out, mem_clock_out, pll_run_out, ref_osc_run_out, sleep_pullup_weak_out;
    logic mode_config_out, prog_refused_out, refused_seen;
    logic [1:0] standby_state_out;
    int n_fail = 0, comparisons = 0, h;
    always #10 ref_clk_in = ~ref_clk_in;
    // pll clocks keep running so the run path is exercised
    always @(posedge ref_clk_in) {pll_video_clk_in, pll_mem_clk_in} <= #1 {~pll_video_clk_in, pll_video_clk_in};
    cgpd_power_ctrl dut (.*);
    cgpd_pm_model u_pm (.ref_clk_in, .sleep_in(sleep_req), .sleep_request_n_out(sleep_request_n_in));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic cmp(input string nm, input logic [4:0] exp, input logic [4:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle write strobe: divider code or mode bit
    task automatic wr(input logic is_div, input logic [3:0] v);
        {div_wr_in, cfg_wr_in, div_code_in, cfg_powerdown_bit_in} = {is_div, !is_div, v, v[0]};
        tick(1);
        refused_seen = prog_refused_out;
        {div_wr_in, cfg_wr_in} = 2'h0;
        tick(1);
    endtask
    // cycles in one level of the memory clock, after aligning to an edge
    task automatic half_period(output int n);
        logic v;
        for (int k = 0; k < 2; k++) begin
            v = mem_clock_out;
            n = 0;
            while (mem_clock_out === v && n < 31) begin
                tick(1);
                n++;
            end
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        n_fail++;
        conclude();
    end
    initial begin
        tick(20);
        reset_n_in = 1;
        tick(1);
        cmp("mode", 5'h0, mode_config_out);
        cmp("code", 5'h8, standby_divider_code_out);
        cmp("pll", 5'h1, pll_run_out);
        // code zero has no divisor of its own and runs as the slowest one
        wr(1, 4'h0);
        sleep_req = 1;
        tick(5);
        half_period(h);
        cmp("half0", 5'h10, 5'(h));
        sleep_req = 0;
        tick(4);
        cmp("code0", 5'h0, standby_divider_code_out);
        $display("standby1 code 0 done");
        for (int c = 1; c < 16; c++) begin
            wr(1, 4'(c));
            cmp("accepted", 5'h0, refused_seen);
            sleep_req = 1;
            tick(5);
            cmp("state", 5'h1, standby_state_out);
            cmp("video", 5'h1, video_clock_out);
            cmp("weak", 5'h1, {pll_run_out, sleep_pullup_weak_out});
            half_period(h);
            cmp("half", 5'(17 - c), 5'(h));
            wr(1, 4'h0);
            cmp("refused", 5'h1, refused_seen);
            cmp("code", 5'(c), standby_divider_code_out);
            sleep_req = 0;
            tick(4);
            cmp("wake", 5'h1, {standby_state_out, sleep_pullup_weak_out, pll_run_out});
            $display("standby1 code %0d done", c);
        end
        wr(0, 4'h1);
        sleep_req = 1;
        tick(5);
        cmp("state2", 5'h2, standby_state_out);
        cmp("quiet", 5'h0, {ref_osc_run_out, video_clock_out, mem_clock_out});
        wr(0, 4'h0);
        cmp("refused2", 5'h1, refused_seen);
        sleep_req = 0;
        tick(4);
        cmp("kept", 5'h1f, {mode_config_out, standby_divider_code_out});
        cmp("osc", 5'h1, ref_osc_run_out);
        $display("standby2 done");
        conclude();
    end
endmodule
